// File: bench/program_counter_core_regs_asserts.sv
/*
 * Port checker for the program counter register block.
 * Assumes one aclk domain and the synchronous active-low aresetn.
 */
`timescale 1ns/1ns
module program_counter_core_regs_asserts (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awready,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic [14:0] pc,
	input logic restore_valid,
	input pc_core_pkg::core_context_s restore_ctx
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_reset_pc: assert property (
		$rose(aresetn) |-> pc == 15'h0000)
		else $error("pc not clear after reset");
	// only a completed write may move the counter
	chk_pc_source: assert property (
		!$stable(pc) |-> $rose(s_axi_bvalid))
		else $error("pc moved without a write");
	chk_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	chk_write_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_read_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_read_refused: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	chk_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0000_00)
		else $error("upper read bits not zero");
	chk_restore_pulse: assert property (
		restore_valid |=> !restore_valid)
		else $error("restore pulse too long");
	chk_restore_hold: assert property (
		!$stable(restore_ctx) |-> restore_valid)
		else $error("restore context moved alone");
endmodule

bind program_counter_core_regs program_counter_core_regs_asserts chk_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .pc(pc), .restore_valid(restore_valid),
	.restore_ctx(restore_ctx));

// File: bench/tb_top.sv
/*
 * Directed register-level bench for the program counter block.
 * Assumes the checker is bound in and a 100 MHz aclk.
 */
`timescale 1ns/1ns
module tb_top;
	logic aclk = 0;
	logic aresetn = 0;
	logic [31:0] s_axi_awaddr = 0;
	logic s_axi_awvalid = 0;
	logic [31:0] s_axi_wdata = 0;
	logic s_axi_wvalid = 0;
	logic s_axi_bready = 0;
	logic [31:0] s_axi_araddr = 0;
	logic s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, restore_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [14:0] pc;
	pc_core_pkg::core_context_s live_ctx = '0;
	pc_core_pkg::core_context_s restore_ctx, ctx_a;
	int mismatches = 0;
	int checks_done = 0;
	int pulses = 0;
	logic [7:0] msk [8] = '{8'h07, 8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff,
		8'hff, 8'hff};

	always #5 aclk = ~aclk;
	always @(posedge aclk) if (restore_valid === 1'b1) pulses++;

	program_counter_core_regs program_counter_core_regs_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.live_ctx(live_ctx), .pc(pc), .restore_valid(restore_valid),
		.restore_ctx(restore_ctx));

	task chk(input logic [47:0] got, input logic [47:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// bready held from the start, so the answer edge ends the write
	task wr(input logic [11:0] i, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {18'h0_0000, i, 2'b00};
		s_axi_wdata <= {24'h0000_00, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, pc_core_pkg::RESP_OKAY);
	endtask

	task rc(input logic [11:0] i, input logic [7:0] e);
		@(posedge aclk);
		s_axi_araddr <= {18'h0_0000, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {40'h0, e});
		chk(s_axi_rresp, pc_core_pkg::RESP_OKAY);
	endtask

	// shadows have no reset, so a second pass checks they survive one
	task shadows(input bit do_write);
		for (int k = 0; k < 8; k++) begin
			if (do_write) wr(pc_core_pkg::IDX_FLAGS_SHADOW + k, 8'hd9 + k);
			rc(pc_core_pkg::IDX_FLAGS_SHADOW + k, (8'hd9 + k) & msk[k]);
		end
	endtask

	task do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task results;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(pc, 0);
		rc(pc_core_pkg::IDX_STACK_INDEX, 8'h1f);
		rc(pc_core_pkg::IDX_PC_LOW, 8'h00);
		wr(pc_core_pkg::IDX_PC_LATCH, 8'hff);
		rc(pc_core_pkg::IDX_PC_LATCH, 8'h7f);
		chk(pc, 0);
		wr(pc_core_pkg::IDX_PC_LATCH, 8'h55);
		wr(pc_core_pkg::IDX_PC_LOW, 8'ha3);
		chk(pc, 15'h55a3);
		rc(pc_core_pkg::IDX_PC_LOW, 8'ha3);
		wr(12'hfe3, 8'hff);
		rc(12'hfe3, 8'h00);
		rc(12'hfec, 8'h00);
		rc(pc_core_pkg::IDX_CORE_CMD, 8'h00);
		wr(pc_core_pkg::IDX_CORE_CMD, 8'h02);
		rc(pc_core_pkg::IDX_STACK_INDEX, 8'h00);
		rc(pc_core_pkg::IDX_STACK_TOP_LOW, 8'ha3);
		rc(pc_core_pkg::IDX_STACK_TOP_HIGH, 8'h55);
		wr(pc_core_pkg::IDX_CORE_CMD, 8'h01);
		chk(pc, 15'h55a4);
		wr(pc_core_pkg::IDX_CORE_CMD, 8'h04);
		chk(pc, 15'h55a3);
		rc(pc_core_pkg::IDX_STACK_INDEX, 8'h1f);
		wr(pc_core_pkg::IDX_STACK_TOP_HIGH, 8'hff);
		rc(pc_core_pkg::IDX_STACK_TOP_HIGH, 8'h7f);
		wr(pc_core_pkg::IDX_STACK_INDEX, 8'he5);
		rc(pc_core_pkg::IDX_STACK_INDEX, 8'h05);
		wr(pc_core_pkg::IDX_STACK_TOP_LOW, 8'h5a);
		rc(pc_core_pkg::IDX_STACK_TOP_LOW, 8'h5a);
		shadows(1);
		do_reset();
		@(posedge aclk);
		chk(pc, 0);
		rc(pc_core_pkg::IDX_STACK_INDEX, 8'h1f);
		shadows(0);
		ctx_a = '{3'h5, 8'h3c, 5'h12, 8'h11, 8'h22, 8'h33, 8'h44};
		live_ctx <= ctx_a;
		wr(pc_core_pkg::IDX_PC_LATCH, 8'h2a);
		wr(pc_core_pkg::IDX_PC_LOW, 8'h10);
		wr(pc_core_pkg::IDX_CORE_CMD, 8'h08);
		rc(pc_core_pkg::IDX_WORKING_SHADOW, 8'h3c);
		rc(pc_core_pkg::IDX_PC_LATCH_SHADOW, 8'h2a);
		live_ctx <= '1;
		wr(pc_core_pkg::IDX_PC_LATCH, 8'h00);
		wr(pc_core_pkg::IDX_PC_LOW, 8'h77);
		chk(pc, 15'h0077);
		wr(pc_core_pkg::IDX_CORE_CMD, 8'h10);
		repeat (2) @(posedge aclk);
		chk(pc, 15'h2a10);
		chk(pulses, 1);
		chk(restore_valid, 1'b0);
		chk(restore_ctx, ctx_a);
		rc(pc_core_pkg::IDX_PC_LATCH, 8'h2a);
		results();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		results();
	end
endmodule

// File: common/pc_core_pkg.sv
/*
 * Shared constants and carriers for the program counter and
 * core register bank: register indices, field widths, reset values,
 * command bit positions and the packed structs passed between modules.
 * Assumes one 100 MHz clock and 32-bit AXI4-Lite register access.
 */
package pc_core_pkg;

	localparam int PC_W = 15;
	localparam int PC_LOW_W = 8;
	localparam int PC_HIGH_W = 7;
	localparam int INDEX_W = 12;
	localparam int STACK_DEPTH = 16;
	localparam int STACK_PTR_W = 5;
	localparam int SHADOW_SLOTS = 8;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_PC_LOW = 12'hfe0;
	localparam logic [11:0] IDX_PC_LATCH = 12'hfe1;
	localparam logic [11:0] IDX_CORE_CMD = 12'hfe2;
	localparam logic [11:0] IDX_FLAGS_SHADOW = 12'hfe4;
	localparam logic [11:0] IDX_WORKING_SHADOW = 12'hfe5;
	localparam logic [11:0] IDX_BANK_SELECT_SHADOW = 12'hfe6;
	localparam logic [11:0] IDX_PC_LATCH_SHADOW = 12'hfe7;
	localparam logic [11:0] IDX_POINTER0_LOW_SHADOW = 12'hfe8;
	localparam logic [11:0] IDX_POINTER0_HIGH_SHADOW = 12'hfe9;
	localparam logic [11:0] IDX_POINTER1_LOW_SHADOW = 12'hfea;
	localparam logic [11:0] IDX_POINTER1_HIGH_SHADOW = 12'hfeb;
	localparam logic [11:0] IDX_STACK_INDEX = 12'hfed;
	localparam logic [11:0] IDX_STACK_TOP_LOW = 12'hfee;
	localparam logic [11:0] IDX_STACK_TOP_HIGH = 12'hfef;

	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam logic [6:0] LATCH_RESET = 7'h00;
	localparam logic [4:0] STACK_EMPTY = 5'h1f;

	// core command register bits, write one to act
	localparam int CMD_STEP_BIT = 0;
	localparam int CMD_CALL_BIT = 1;
	localparam int CMD_RETURN_BIT = 2;
	localparam int CMD_IRQ_ENTRY_BIT = 3;
	localparam int CMD_IRQ_RETURN_BIT = 4;

	// implemented bits of each shadow slot and of the stack top high byte
	localparam logic [7:0] FLAGS_MASK = 8'h07;
	localparam logic [7:0] BANK_MASK = 8'h1f;
	localparam logic [7:0] LATCH_MASK = 8'h7f;
	localparam logic [7:0] FULL_MASK = 8'hff;
	localparam logic [7:0] TOP_HIGH_MASK = 8'h7f;

	localparam logic [1:0] RESP_OKAY = 2'b00;

	typedef struct packed {
		logic valid;
		logic [11:0] index;
		logic [7:0] data;
	} reg_write_s;

	typedef struct packed {
		logic [2:0] flags;
		logic [7:0] working;
		logic [4:0] bank;
		logic [7:0] ptr0_low;
		logic [7:0] ptr0_high;
		logic [7:0] ptr1_low;
		logic [7:0] ptr1_high;
	} core_context_s;

	function automatic logic [7:0] shadow_mask(input logic [2:0] slot);
		case (slot)
			3'h0: shadow_mask = FLAGS_MASK;
			3'h2: shadow_mask = BANK_MASK;
			3'h3: shadow_mask = LATCH_MASK;
			default: shadow_mask = FULL_MASK;
		endcase
	endfunction

endpackage

// File: rtl/context_shadow.sv
/*
 * Eight shadow bytes for the core context: flags, working, bank select,
 * holding latch and both indirect pointers. No reset on purpose.
 * Assumes capture and software write never coincide.
 */
`timescale 1ns/1ns
module context_shadow (
	input logic aclk,
	input logic capture,
	input pc_core_pkg::core_context_s live_ctx,
	input logic [6:0] live_latch,
	input logic sw_wr,
	input logic [2:0] sw_slot,
	input logic [7:0] sw_data,
	input logic [2:0] rd_slot,
	output logic [7:0] rd_byte,
	output pc_core_pkg::core_context_s saved_ctx,
	output logic [6:0] saved_latch
);
	logic [7:0] slot_q [8];
	logic [7:0] next_slot [8];

	assign rd_byte = slot_q[rd_slot];
	assign saved_ctx = '{flags: slot_q[0][2:0], working: slot_q[1],
		bank: slot_q[2][4:0], ptr0_low: slot_q[4], ptr0_high: slot_q[5],
		ptr1_low: slot_q[6], ptr1_high: slot_q[7]};
	assign saved_latch = slot_q[3][6:0];

	always_comb begin
		next_slot = slot_q;
		if (capture) begin
			next_slot[0] = {5'h00, live_ctx.flags}; // [RQ14]
			next_slot[1] = live_ctx.working;
			next_slot[2] = {3'h0, live_ctx.bank};
			next_slot[3] = {1'b0, live_latch}; // [RQ10]
			next_slot[4] = live_ctx.ptr0_low; // [RQ11]
			next_slot[5] = live_ctx.ptr0_high;
			next_slot[6] = live_ctx.ptr1_low;
			next_slot[7] = live_ctx.ptr1_high;
		end else if (sw_wr) begin
			// unimplemented bits stay zero
			next_slot[sw_slot] = sw_data & pc_core_pkg::shadow_mask(sw_slot); // [RQ7]
		end
	end

	// unreset: shadows keep their value through every reset
	always_ff @(posedge aclk) begin
		slot_q <= next_slot; // [RQ10] [RQ11]
	end
endmodule

// File: rtl/program_counter_core_regs.sv
/*
 * Program counter with writable low byte and high holding latch, return
 * stack views and core context shadows, reached over AXI4-Lite.
 * Assumes a 100 MHz aclk, synchronous active-low reset, and a core that
 * supplies its live context and takes back the restored one.
 */
// Our own choice: the AXI4-Lite register port.
// Function
// [RQ1] program counter is fifteen bits, low and high
// [RQ2] low counter byte readable and writable
// [RQ3] upper counter bits only through holding latch
// [RQ4] every reset clears the program counter
// [RQ5] low byte write loads upper bits from latch
// [RQ6] all fifteen bits change together on write
// [RQ7] unimplemented locations and bits read zero
// [RQ8] register shows low byte of stack top
// [RQ9] register shows upper seven stack top bits
// [RQ10] latch shadow seven bits, kept through resets
// [RQ11] pointer shadows eight bits, kept through resets
// [RQ12] empty stack index is all ones
// [RQ13] call increments index, then stores counter
// [RQ14] interrupt entry captures, return restores context
`timescale 1ns/1ns
module program_counter_core_regs (
	input logic aclk,
	input logic aresetn,
	input logic [31:0] s_axi_awaddr,
	input logic [2:0] s_axi_awprot,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [31:0] s_axi_araddr,
	input logic [2:0] s_axi_arprot,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input pc_core_pkg::core_context_s live_ctx,
	output logic [14:0] pc,
	output logic restore_valid,
	output pc_core_pkg::core_context_s restore_ctx
);
	// ---- AXI4-Lite slave state ----
	logic aw_full;
	logic [31:0] aw_addr;
	logic w_full;
	logic [7:0] w_data;
	logic w_lane0;
	logic next_aw_full;
	logic [31:0] next_aw_addr;
	logic next_w_full;
	logic [7:0] next_w_data;
	logic next_w_lane0;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;

	// ---- core state ----
	logic [6:0] latch;
	logic [14:0] next_pc;
	logic [6:0] next_latch;
	logic next_restore_valid;
	pc_core_pkg::core_context_s next_restore_ctx;

	pc_core_pkg::reg_write_s wr;
	logic [11:0] rd_index;
	logic rd_ok;
	logic [7:0] rd_byte;
	logic push;
	logic pop;
	logic capture;
	logic [4:0] stack_idx;
	logic [14:0] stack_top;
	logic shadow_wr;
	logic [2:0] shadow_slot;
	logic [2:0] shadow_rd_slot;
	logic [7:0] shadow_rd_byte;
	pc_core_pkg::core_context_s saved_ctx;
	logic [6:0] saved_latch;

	// word aligned and inside the 4096-word window, else unmapped
	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a[31:14] == 18'h0_0000) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic is_shadow(input logic [11:0] idx);
		is_shadow = (idx >= pc_core_pkg::IDX_FLAGS_SHADOW) &&
			(idx <= pc_core_pkg::IDX_POINTER1_HIGH_SHADOW);
	endfunction

	function automatic logic [2:0] slot_of(input logic [11:0] idx);
		logic [11:0] d;
		d = idx - pc_core_pkg::IDX_FLAGS_SHADOW;
		slot_of = d[2:0];
	endfunction

	// ---- write path: address and data taken in either order ----
	always_comb begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = s_axi_bvalid;
		wr = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (aw_full && w_full && !s_axi_bvalid) begin
			// only lane 0 holds data; unmapped writes vanish
			wr.valid = addr_ok(aw_addr) && w_lane0; // [RQ7]
			wr.index = aw_addr[13:2];
			wr.data = w_data;
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
	end

	// ---- read path: one cycle from address to data ----
	assign rd_index = s_axi_araddr[13:2];
	assign rd_ok = addr_ok(s_axi_araddr);
	assign shadow_rd_slot = slot_of(rd_index);

	always_comb begin
		rd_byte = 8'h00; // [RQ7]
		case (rd_index)
			pc_core_pkg::IDX_PC_LOW: rd_byte = pc[7:0]; // [RQ2]
			pc_core_pkg::IDX_PC_LATCH: rd_byte = {1'b0, latch};
			pc_core_pkg::IDX_STACK_INDEX: rd_byte = {3'h0, stack_idx};
			pc_core_pkg::IDX_STACK_TOP_LOW: rd_byte = stack_top[7:0]; // [RQ8]
			pc_core_pkg::IDX_STACK_TOP_HIGH:
				rd_byte = {1'b0, stack_top[14:8]}; // [RQ9]
			default: begin
				if (is_shadow(rd_index)) begin
					rd_byte = shadow_rd_byte;
				end
			end
		endcase
		// upper counter bits have no read path of their own [RQ3]
	end

	always_comb begin
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000; // [RQ7]
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_full <= 1'b0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
		end
	end

	assign s_axi_bresp = pc_core_pkg::RESP_OKAY;
	assign s_axi_rresp = pc_core_pkg::RESP_OKAY;

	// ---- program counter, latch and core commands ----
	always_comb begin
		next_pc = pc;
		next_latch = latch;
		push = 1'b0;
		pop = 1'b0;
		capture = 1'b0;
		next_restore_valid = 1'b0;
		next_restore_ctx = restore_ctx;
		if (wr.valid) begin
			case (wr.index)
				pc_core_pkg::IDX_PC_LOW: begin
					// one write moves all fifteen bits at once
					next_pc = {latch, wr.data}; // [RQ5] [RQ6] [RQ3]
				end
				pc_core_pkg::IDX_PC_LATCH: begin
					next_latch = wr.data[6:0];
				end
				pc_core_pkg::IDX_CORE_CMD: begin
					// one command per write; highest bit wins
					if (wr.data[pc_core_pkg::CMD_IRQ_RETURN_BIT]) begin
						pop = 1'b1;
						next_pc = stack_top;
						next_latch = saved_latch; // [RQ14]
						next_restore_valid = 1'b1;
						next_restore_ctx = saved_ctx; // [RQ14]
					end else if (wr.data[pc_core_pkg::CMD_IRQ_ENTRY_BIT]) begin
						push = 1'b1;
						capture = 1'b1; // [RQ14]
					end else if (wr.data[pc_core_pkg::CMD_RETURN_BIT]) begin
						pop = 1'b1;
						next_pc = stack_top;
					end else if (wr.data[pc_core_pkg::CMD_CALL_BIT]) begin
						push = 1'b1; // [RQ13]
					end else if (wr.data[pc_core_pkg::CMD_STEP_BIT]) begin
						next_pc = 15'(pc + 15'h0001); // [RQ1]
					end
				end
				default: begin
					next_pc = pc;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc <= pc_core_pkg::PC_RESET; // [RQ4]
			latch <= pc_core_pkg::LATCH_RESET;
			restore_valid <= 1'b0;
			restore_ctx <= '0;
		end else begin
			pc <= next_pc;
			latch <= next_latch;
			restore_valid <= next_restore_valid;
			restore_ctx <= next_restore_ctx;
		end
	end

	// ---- software writes into stack and shadows ----
	assign shadow_wr = wr.valid && is_shadow(wr.index);
	assign shadow_slot = slot_of(wr.index);

	return_stack u_stack (
		.aclk(aclk),
		.aresetn(aresetn),
		.push(push),
		.pop(pop),
		.push_value(pc),
		.index_wr(wr.valid && wr.index == pc_core_pkg::IDX_STACK_INDEX),
		.top_low_wr(wr.valid && wr.index == pc_core_pkg::IDX_STACK_TOP_LOW),
		.top_high_wr(wr.valid && wr.index == pc_core_pkg::IDX_STACK_TOP_HIGH),
		.wdata(wr.data),
		.index(stack_idx),
		.top(stack_top)
	);

	context_shadow u_shadow (
		.aclk(aclk),
		.capture(capture),
		.live_ctx(live_ctx),
		.live_latch(latch),
		.sw_wr(shadow_wr),
		.sw_slot(shadow_slot),
		.sw_data(wr.data),
		.rd_slot(shadow_rd_slot),
		.rd_byte(shadow_rd_byte),
		.saved_ctx(saved_ctx),
		.saved_latch(saved_latch)
	);

	// prot inputs carry no meaning for this block
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8],
		s_axi_wstrb[3:1], aw_addr[31:14], aw_addr[1:0]};
endmodule

// File: rtl/return_stack.sv
/*
 * Sixteen-entry return stack with a five-bit index and a writable top.
 * Assumes at most one of push, pop and the software writes per cycle.
 */
`timescale 1ns/1ns
module return_stack (
	input logic aclk,
	input logic aresetn,
	input logic push,
	input logic pop,
	input logic [14:0] push_value,
	input logic index_wr,
	input logic top_low_wr,
	input logic top_high_wr,
	input logic [7:0] wdata,
	output logic [4:0] index,
	output logic [14:0] top
);
	logic [14:0] slots [16];
	logic [4:0] next_index;
	logic mem_we;
	logic [3:0] mem_addr;
	logic [14:0] mem_data;

	assign top = slots[index[3:0]];

	always_comb begin
		next_index = index;
		mem_we = 1'b0;
		mem_addr = index[3:0];
		mem_data = top;
		if (push) begin
			// index moves first, then the slot it names is written
			next_index = 5'(index + 5'h01); // [RQ13]
			mem_we = 1'b1;
			mem_addr = next_index[3:0]; // [RQ13]
			mem_data = push_value;
		end else if (pop) begin
			// popping the last entry lands back on the empty value
			next_index = 5'(index - 5'h01); // [RQ12]
		end else if (index_wr) begin
			next_index = wdata[4:0];
		end else if (top_low_wr) begin
			mem_we = 1'b1;
			mem_data = {top[14:8], wdata};
		end else if (top_high_wr) begin
			mem_we = 1'b1;
			mem_data = {wdata[6:0], top[7:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			index <= pc_core_pkg::STACK_EMPTY; // [RQ12]
		end else begin
			index <= next_index;
		end
		// slot contents survive reset
		if (mem_we) begin
			slots[mem_addr] <= mem_data;
		end
	end
endmodule
